// >>> common/boot_mode_cfg.svh
`ifndef BOOT_MODE_CFG_SVH
`define BOOT_MODE_CFG_SVH
`define CRC_HI_ADDR 16'hffb8
`define CRC_LO_ADDR 16'hffb9
`define SKIP_ADDR 16'hffba
`define RANGE1_LO 16'hc400
`define RANGE1_HI 16'hffad
`define RANGE2_LO 16'hffc0
`define RANGE2_HI 16'hffff
`define SKIP_USER 8'h00
`define SKIP_CHECK 8'hff
`define REENTRY_CODE 8'hc3
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'haa
`define SP_RESET 16'h00ff
`define DIRECT_PAGE_TOP 16'h0100
`define CRC_POLY 16'h1021
`define CRC_SEED 16'hffff
`endif

// >>> common/boot_mode_pkg.sv
package boot_mode_pkg;
  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_LOADER,
    MODE_USER,
    MODE_DEBUG
  } boot_mode_t;

  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } flash_req_t;

  typedef struct packed {
    logic req;
    logic from_debug;
    logic from_secure;
    logic bit_op;
    logic [15:0] addr;
  } ram_req_t;
endpackage : boot_mode_pkg

// >>> hdl/crc16_unit.sv
`timescale 1ns/1ps
`include "boot_mode_cfg.svh"
module crc16_unit
  import boot_mode_pkg::*;
(
  input wire logic i_clk, // System clock.
  input wire logic i_sys_rst, // Synchronous reset, active high.
  input wire logic i_clear, // Load the seed value.
  input wire logic i_valid, // Fold in one data byte.
  input wire logic [7:0] i_data, // Data byte.
  output logic [15:0] o_crc // Running CRC.
);
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  always_comb begin
    crc_nxt = crc_r;
    for (int i = 7; i >= 0; i--) begin
      if (crc_nxt[15] ^ i_data[i]) begin
        crc_nxt = {crc_nxt[14:0], 1'b0} ^ `CRC_POLY;
      end else begin
        crc_nxt = {crc_nxt[14:0], 1'b0};
      end
    end
  end

  // The image checksum is a 16-bit CRC folded in one byte at a time.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_clear) begin
      crc_r <= `CRC_SEED;
    end else if (i_valid) begin
      crc_r <= crc_nxt;
    end
  end

  assign o_crc = crc_r;
endmodule : crc16_unit

// >>> hdl/boot_mode_selector.sv
`timescale 1ns/1ps
`include "boot_mode_cfg.svh"
module boot_mode_selector
  import boot_mode_pkg::*;
#(
  parameter int FLASH_LATENCY = 1
)
(
  input wire logic i_clk, // System clock, 50 MHz.
  input wire logic i_sys_rst, // Synchronous reset, active high.
  input wire logic i_por, // High with reset when it is a power-on reset.
  input wire logic i_boot_select_pin, // Boot-select pin level.
  input wire logic i_debug_mode_pin, // Debug mode pin level.
  input wire logic [7:0] i_reentry_semaphore, // Re-entry semaphore byte.
  input wire logic [7:0] i_flash_rdata, // Flash read data.
  input wire logic i_flash_rvalid, // Flash read data valid.
  input wire logic i_prot_wr, // Write strobe to the protection defeat reg.
  input wire logic [7:0] i_prot_wdata, // Data for the protection defeat reg.
  input wire logic i_block_prot_wr, // Write strobe to the block protect reg.
  input wire logic i_protection_disable_bit, // Disable bit in that write.
  input wire logic i_secure, // Security engaged.
  input wire ram_req_t i_ram_req, // RAM access request.
  output flash_req_t o_flash_req, // Flash read request.
  output boot_mode_t o_mode, // Selected boot mode.
  output logic o_mode_valid, // Mode decided and latched.
  output logic o_usb_reg_en, // USB voltage regulator enable.
  output logic o_prot_disabled, // Flash block protection defeated.
  output logic [15:0] o_stack_ptr, // Stack pointer reset value.
  output logic o_ram_grant, // RAM access allowed.
  output logic o_ram_direct // RAM access is direct-page capable.
);
  // ****************************************************************
  // Qualification sequencer
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_SKIP,
    ST_RD_HI,
    ST_RD_LO,
    ST_CRC,
    ST_CMP,
    ST_DONE
  } state_t;

  state_t state_r;
  logic por_seen_r;
  logic pin_boot_r;
  logic pin_dbg_r;
  logic [15:0] stored_r;
  logic [15:0] addr_r;
  logic rd_pend_r;
  logic crc_clear;
  logic crc_valid;
  logic [15:0] crc_val;
  logic [15:0] next_addr;
  boot_mode_t mode_r;
  logic valid_r;
  flash_req_t flash_req_r;

  crc16_unit u_crc (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(crc_clear),
    .i_valid(crc_valid),
    .i_data(i_flash_rdata),
    .o_crc(crc_val)
  );

  // Skip the configuration gap between the two covered ranges.
  always_comb begin
    if (addr_r == `RANGE1_HI) begin
      next_addr = `RANGE2_LO;
    end else begin
      next_addr = addr_r + 16'h0001;
    end
  end

  assign crc_clear = (state_r == ST_RD_LO) && i_flash_rvalid;
  assign crc_valid = (state_r == ST_CRC) && i_flash_rvalid;

  // ****************************************************************
  // Reset kind and pin capture
  // ****************************************************************
  // Reset kind is captured while reset is held; pins only when it is a power-on reset.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      por_seen_r <= i_por;
      if (i_por) begin
        pin_boot_r <= i_boot_select_pin;
        pin_dbg_r <= i_debug_mode_pin;
      end
    end
  end

  // ****************************************************************
  // Flash read requests
  // ****************************************************************
  // Only one read is outstanding at a time.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flash_req_r <= '0;
      rd_pend_r <= 1'b0;
    end else if (state_r inside {ST_RD_SKIP, ST_RD_HI, ST_RD_LO, ST_CRC}
                 && !rd_pend_r && !flash_req_r.req) begin
      flash_req_r.req <= 1'b1;
      flash_req_r.addr <= addr_r;
      rd_pend_r <= 1'b1;
    end else begin
      flash_req_r.req <= 1'b0;
      if (i_flash_rvalid) begin
        rd_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Decision state machine
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (!por_seen_r || !pin_boot_r) begin
            state_r <= ST_DONE;
          end else begin
            state_r <= ST_RD_SKIP;
          end
        end
        ST_RD_SKIP: begin
          if (i_flash_rvalid && i_flash_rdata == `SKIP_CHECK) begin
            state_r <= ST_RD_HI;
          end else if (i_flash_rvalid) begin
            state_r <= ST_DONE;
          end
        end
        ST_RD_HI: begin
          if (i_flash_rvalid) begin
            state_r <= ST_RD_LO;
          end
        end
        ST_RD_LO: begin
          if (i_flash_rvalid) begin
            state_r <= ST_CRC;
          end
        end
        ST_CRC: begin
          if (i_flash_rvalid && addr_r == `RANGE2_HI) begin
            state_r <= ST_CMP;
          end
        end
        ST_CMP: begin
          state_r <= ST_DONE;
        end
        default: begin
          state_r <= ST_DONE;
        end
      endcase
    end
  end

  // The last image byte is folded on entry to ST_CMP, so the compare waits one cycle.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_r <= MODE_NONE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (!por_seen_r && i_reentry_semaphore == `REENTRY_CODE) begin
            mode_r <= MODE_LOADER;
          end else if (!por_seen_r) begin
            mode_r <= MODE_USER;
          end else if (!pin_boot_r && !pin_dbg_r) begin
            mode_r <= MODE_DEBUG;
          end else if (!pin_boot_r) begin
            mode_r <= MODE_LOADER;
          end
        end
        ST_RD_SKIP: begin
          if (i_flash_rvalid && i_flash_rdata == `SKIP_USER) begin
            mode_r <= MODE_USER;
          end else if (i_flash_rvalid && i_flash_rdata != `SKIP_CHECK) begin
            mode_r <= MODE_LOADER;
          end
        end
        ST_CMP: begin
          if (crc_val == stored_r) begin
            mode_r <= MODE_USER;
          end else begin
            mode_r <= MODE_LOADER;
          end
        end
        default: begin
          mode_r <= mode_r;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      valid_r <= 1'b0;
    end else if (state_r == ST_DONE) begin
      valid_r <= 1'b1;
    end
  end

  // Address of the next flash byte to request.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      addr_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          addr_r <= `SKIP_ADDR;
        end
        ST_RD_SKIP: begin
          if (i_flash_rvalid) begin
            addr_r <= `CRC_HI_ADDR;
          end
        end
        ST_RD_HI: begin
          if (i_flash_rvalid) begin
            addr_r <= `CRC_LO_ADDR;
          end
        end
        ST_RD_LO: begin
          if (i_flash_rvalid) begin
            addr_r <= `RANGE1_LO;
          end
        end
        ST_CRC: begin
          if (i_flash_rvalid) begin
            addr_r <= next_addr;
          end
        end
        default: begin
          addr_r <= addr_r;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      stored_r <= '0;
    end else if (state_r == ST_RD_HI && i_flash_rvalid) begin
      stored_r[15:8] <= i_flash_rdata;
    end else if (state_r == ST_RD_LO && i_flash_rvalid) begin
      stored_r[7:0] <= i_flash_rdata;
    end
  end

  // ****************************************************************
  // Latched outputs
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_mode <= MODE_NONE;
      o_mode_valid <= 1'b0;
      o_usb_reg_en <= 1'b0;
    end else if (valid_r && !o_mode_valid) begin
      o_mode <= mode_r;
      o_mode_valid <= 1'b1;
      o_usb_reg_en <= (mode_r == MODE_LOADER);
    end
  end

  assign o_flash_req = flash_req_r;

  // ****************************************************************
  // Protection defeat sequence
  // ****************************************************************
  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_KEY1,
    UNL_ARMED
  } unlock_t;

  unlock_t unlock_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      unlock_r <= UNL_IDLE;
      o_prot_disabled <= 1'b0;
    end else begin
      if (i_prot_wr) begin
        if (i_prot_wdata == `UNLOCK_KEY1) begin
          unlock_r <= UNL_KEY1;
        end else if (i_prot_wdata == `UNLOCK_KEY2 && unlock_r == UNL_KEY1) begin
          unlock_r <= UNL_ARMED;
        end else begin
          unlock_r <= UNL_IDLE;
        end
      end else if (i_block_prot_wr) begin
        if (unlock_r == UNL_ARMED && i_protection_disable_bit) begin
          o_prot_disabled <= 1'b1;
        end
        unlock_r <= UNL_IDLE;
      end
    end
  end

  // ****************************************************************
  // Stack pointer and RAM access gate
  // ****************************************************************
  // RAM contents live outside this block and are never cleared here.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_stack_ptr <= `SP_RESET;
      o_ram_grant <= 1'b0;
      o_ram_direct <= 1'b0;
    end else begin
      o_ram_grant <= i_ram_req.req
                     && !(i_secure && (i_ram_req.from_debug
                     || !i_ram_req.from_secure));
      o_ram_direct <= i_ram_req.req
                      && (i_ram_req.addr < `DIRECT_PAGE_TOP);
    end
  end
endmodule : boot_mode_selector

// >>> testbench/flash_image_model.sv
`timescale 1ns/1ps
module flash_image_model
  import boot_mode_pkg::*;
(
  input wire logic i_clk, // Clock.
  input wire flash_req_t i_req, // Read request.
  input wire logic [7:0] i_skip, // Skip byte.
  input wire logic [15:0] i_crc, // Stored CRC.
  input wire logic [1:0] i_wait, // Extra delay.
  output logic [7:0] o_rdata, // Read data.
  output logic o_rvalid // Data valid.
);
  // ********************************
  // Flash image answering one read at a time.
  // ********************************
  logic [15:0] a = 16'h0000;
  logic [7:0] last = 8'h00;
  logic [2:0] cnt = 3'h0;
  initial o_rvalid = 1'b0;
  initial o_rdata = 8'h00;
  function automatic logic [7:0] byte_at(logic [15:0] x);
    case (x)
      16'hffb8: return i_crc[15:8];
      16'hffb9: return i_crc[7:0];
      16'hffba: return i_skip;
      default: return x[7:0] ^ x[15:8];
    endcase
  endfunction : byte_at
  // Between answers the data lines show the inverse of the last byte.
  always @(posedge i_clk) begin
    o_rvalid <= 1'b0;
    o_rdata <= ~last;
    // With no extra delay the answer comes on the edge that sees the request.
    if (i_req.req && i_wait == 2'h0) begin
      o_rvalid <= 1'b1;
      o_rdata <= byte_at(i_req.addr);
      last <= byte_at(i_req.addr);
    end else if (i_req.req) begin
      a <= i_req.addr;
      cnt <= 3'(i_wait);
    end else if (cnt == 3'h1) begin
      o_rvalid <= 1'b1;
      o_rdata <= byte_at(a);
      last <= byte_at(a);
      cnt <= 3'h0;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
endmodule : flash_image_model

// >>> testbench/boot_mode_selector_properties.sv
`timescale 1ns/1ps
`include "boot_mode_cfg.svh"
module boot_mode_selector_properties
  import boot_mode_pkg::*;
(
  input wire logic i_clk, // Clock.
  input wire logic i_sys_rst, // Reset.
  input wire logic i_por, // Power-on.
  input wire logic i_boot_select_pin, // Boot pin.
  input wire logic i_debug_mode_pin, // Debug pin.
  input wire logic [7:0] i_reentry_semaphore, // Semaphore.
  input wire logic i_block_prot_wr, // Protect write.
  input wire logic i_protection_disable_bit, // Disable bit.
  input wire logic i_secure, // Security.
  input wire ram_req_t i_ram_req, // RAM request.
  input wire flash_req_t o_flash_req, // Flash request.
  input wire boot_mode_t o_mode, // Mode.
  input wire logic o_mode_valid, // Latched.
  input wire logic o_usb_reg_en, // Regulator.
  input wire logic o_prot_disabled, // Defeated.
  input wire logic [15:0] o_stack_ptr, // Stack pointer.
  input wire logic o_ram_grant, // Grant.
  input wire logic o_ram_direct // Direct page.
);
  // ********************************
  // Qualifiers captured while reset is held.
  // ********************************
  logic por_r, bs_r, dm_r, first_r;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      por_r <= i_por;
      bs_r <= i_boot_select_pin;
      dm_r <= i_debug_mode_pin;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      first_r <= 1'b1;
    end else if (o_flash_req.req) begin
      first_r <= 1'b0;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  mode_hold_a: assert property (o_mode_valid |=> o_mode_valid && $stable(o_mode))
    else $error("mode changed after latch");
  usb_loader_a: assert property (o_mode_valid |-> o_usb_reg_en == (o_mode == MODE_LOADER))
    else $error("regulator does not follow loader mode");
  pin_mode_a: assert property (o_mode_valid && por_r && !bs_r
    |-> o_mode == (dm_r ? MODE_LOADER : MODE_DEBUG)) else $error("pin mode wrong");
  reentry_mode_a: assert property (o_mode_valid && !por_r |-> o_mode ==
    ((i_reentry_semaphore == `REENTRY_CODE) ? MODE_LOADER : MODE_USER)) else $error("reentry");
  quick_decide_a: assert property ($fell(i_sys_rst) && !por_r |-> ##[1:8] o_mode_valid)
    else $error("warm reset decision late");
  flash_por_a: assert property (o_flash_req.req |-> por_r && bs_r && dm_r)
    else $error("flash read outside power-on path");
  skip_first_a: assert property (o_flash_req.req && first_r |-> o_flash_req.addr == `SKIP_ADDR)
    else $error("first flash read not skip byte");
  stack_reset_a: assert property ($fell(i_sys_rst) |-> o_stack_ptr == `SP_RESET && !o_mode_valid)
    else $error("reset values wrong");
  unlock_cause_a: assert property ($rose(o_prot_disabled)
    |-> $past(i_block_prot_wr && i_protection_disable_bit)) else $error("unlock without bit");
  ram_grant_a: assert property (1'b1 |=> o_ram_grant == $past(i_ram_req.req &&
    !(i_secure && (i_ram_req.from_debug || !i_ram_req.from_secure)))) else $error("grant");
  ram_direct_a: assert property (i_ram_req.req
    |=> o_ram_direct == ($past(i_ram_req.addr) < `DIRECT_PAGE_TOP)) else $error("direct");
endmodule : boot_mode_selector_properties
bind boot_mode_selector boot_mode_selector_properties chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_por(i_por), .i_boot_select_pin(i_boot_select_pin), .i_debug_mode_pin(i_debug_mode_pin),
  .i_reentry_semaphore(i_reentry_semaphore), .i_block_prot_wr(i_block_prot_wr),
  .i_protection_disable_bit(i_protection_disable_bit), .i_secure(i_secure),
  .i_ram_req(i_ram_req), .o_flash_req(o_flash_req), .o_mode(o_mode),
  .o_mode_valid(o_mode_valid), .o_usb_reg_en(o_usb_reg_en), .o_prot_disabled(o_prot_disabled),
  .o_stack_ptr(o_stack_ptr), .o_ram_grant(o_ram_grant), .o_ram_direct(o_ram_direct));

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`include "boot_mode_cfg.svh"
module testbench;
  import boot_mode_pkg::*;
  logic i_clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic bs = 1'b1;
  logic dm = 1'b1;
  logic rvalid, valid, usb, pdis, grant, direct;
  logic pwr = 1'b0;
  logic bwr = 1'b0;
  logic pbit = 1'b0;
  logic sec = 1'b0;
  logic [7:0] sem = 8'h00;
  logic [7:0] pdata = 8'h00;
  logic [7:0] skip = 8'hff;
  logic [7:0] rdata;
  logic [15:0] crc = 16'h0000;
  logic [15:0] sp;
  logic [1:0] wt = 2'h2;
  ram_req_t ram = '0;
  flash_req_t freq;
  boot_mode_t mode;
  int errors = 0;
  int tests_run = 0;
  always #10 i_clk = ~i_clk;
  boot_mode_selector dut (.i_clk(i_clk), .i_sys_rst(rst), .i_por(por), .i_boot_select_pin(bs),
    .i_debug_mode_pin(dm), .i_reentry_semaphore(sem), .i_flash_rdata(rdata),
    .i_flash_rvalid(rvalid), .i_prot_wr(pwr), .i_prot_wdata(pdata), .i_block_prot_wr(bwr),
    .i_protection_disable_bit(pbit), .i_secure(sec), .i_ram_req(ram), .o_flash_req(freq),
    .o_mode(mode), .o_mode_valid(valid), .o_usb_reg_en(usb), .o_prot_disabled(pdis),
    .o_stack_ptr(sp), .o_ram_grant(grant), .o_ram_direct(direct));
  flash_image_model flash (.i_clk(i_clk), .i_req(freq), .i_skip(skip), .i_crc(crc),
    .i_wait(wt), .o_rdata(rdata), .o_rvalid(rvalid));
  // ********************************
  // Shared checking and sequencing tasks.
  // ********************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // The pins flip after release, so a late sample of them shows up as a wrong mode.
  task automatic boot(logic p, logic b, logic d, logic [7:0] s, logic [7:0] k, boot_mode_t m);
    @(negedge i_clk);
    rst = 1'b1;
    por = p;
    bs = b;
    dm = d;
    sem = s;
    skip = k;
    repeat (16) @(negedge i_clk);
    rst = 1'b0;
    por = 1'b0;
    bs = ~b;
    dm = ~d;
    check("stack", sp, `SP_RESET);
    for (int n = 0; n < 60000 && valid !== 1'b1; n++) @(negedge i_clk);
    if (valid !== 1'b1) begin
      errors++;
      print_verdict();
    end
    check("mode", 16'(mode), 16'(m));
    check("usb", 16'(usb), 16'(m == MODE_LOADER));
  endtask : boot
  function automatic logic [15:0] img_crc();
    logic [15:0] c;
    logic [7:0] d;
    c = `CRC_SEED;
    for (int a = 'hc400; a <= 'hffff; a++) begin
      if (a > 'hffad && a < 'hffc0) continue;
      d = 8'(a) ^ 8'(a >> 8);
      c = c ^ {d, 8'h00};
      for (int b = 0; b < 8; b++) c = c[15] ? {c[14:0], 1'b0} ^ `CRC_POLY : {c[14:0], 1'b0};
    end
    return c;
  endfunction : img_crc
  task automatic wr(logic blk, logic [7:0] d);
    @(negedge i_clk);
    pwr = ~blk;
    pdata = d;
    bwr = blk;
    pbit = blk & d[0];
    @(negedge i_clk);
    pwr = 1'b0;
    bwr = 1'b0;
  endtask : wr
  // ********************************
  // Scenarios.
  // ********************************
  task automatic t_pins();
    boot(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, MODE_LOADER);
    boot(1'b1, 1'b0, 1'b0, 8'h00, 8'h5a, MODE_DEBUG);
  endtask : t_pins
  task automatic t_skip();
    boot(1'b1, 1'b1, 1'b1, 8'hc3, 8'h00, MODE_USER);
    boot(1'b1, 1'b1, 1'b1, 8'h00, 8'h01, MODE_LOADER);
    boot(1'b1, 1'b1, 1'b1, 8'h00, 8'hfe, MODE_LOADER);
  endtask : t_skip
  task automatic t_reentry();
    boot(1'b0, 1'b0, 1'b0, 8'hc3, 8'h00, MODE_LOADER);
    boot(1'b0, 1'b0, 1'b1, 8'hc2, 8'h5a, MODE_USER);
  endtask : t_reentry
  task automatic t_crc();
    wt = 2'h0;
    crc = img_crc();
    boot(1'b1, 1'b1, 1'b1, 8'h00, 8'hff, MODE_USER);
    crc = crc ^ 16'h0100;
    boot(1'b1, 1'b1, 1'b1, 8'h00, 8'hff, MODE_LOADER);
  endtask : t_crc
  task automatic t_protect();
    wr(1'b0, `UNLOCK_KEY1);
    wr(1'b0, 8'h00);
    wr(1'b0, `UNLOCK_KEY2);
    wr(1'b1, 8'h01);
    check("unlock bad order", 16'(pdis), 16'h0000);
    wr(1'b0, `UNLOCK_KEY1);
    wr(1'b0, `UNLOCK_KEY2);
    wr(1'b1, 8'h00);
    check("unlock no bit", 16'(pdis), 16'h0000);
    wr(1'b0, `UNLOCK_KEY1);
    wr(1'b0, `UNLOCK_KEY2);
    wr(1'b1, 8'h01);
    check("unlock", 16'(pdis), 16'h0001);
  endtask : t_protect
  task automatic t_ram();
    for (int i = 0; i < 16; i++) begin
      @(negedge i_clk);
      ram = '{1'b1, i[0], i[1], i[3], (i[2] ? 16'h0100 : 16'h00ff)};
      sec = i[3] | i[2];
      @(negedge i_clk);
      check("grant", 16'(grant), 16'(!(sec && (ram.from_debug || !ram.from_secure))));
      check("direct", 16'(direct), 16'(!i[2]));
    end
    ram = '0;
  endtask : t_ram
  initial begin
    t_pins();
    t_skip();
    t_reentry();
    t_protect();
    t_ram();
    t_crc();
    print_verdict();
  end
endmodule : testbench
